// ---- bench/dsh_host_model.sv ----
// Host model: mode commands and register accesses.
// Assumes the link is decoded into strobes on CLK.
`timescale 1ns/10ps
`default_nettype none
module dsh_host_model (
  input wire logic CLK,
  input wire logic [15:0] HOST_RDATA,
  output logic HOST_CMD_VALID,
  output logic [7:0] HOST_CMD_CODE,
  output dsh_pkg::dsh_host_req_t HOST_REQ
);
  import dsh_pkg::*;
  // Idle port at time zero.
  initial begin
    HOST_CMD_VALID = 1'b0;
    HOST_CMD_CODE = 8'h5a;
    HOST_REQ = '0;
  end
  // One mode command pulse, code inverted afterwards.
  task automatic send_cmd(input logic [7:0] code);
    @(posedge CLK);
    #1;
    HOST_CMD_VALID = 1'b1;
    HOST_CMD_CODE = code;
    @(posedge CLK);
    #1;
    HOST_CMD_VALID = 1'b0;
    HOST_CMD_CODE = ~code;
  endtask
  // One write pulse; stale data is inverted afterwards.
  task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    #1;
    HOST_REQ = '{wr: 1'b1, addr: a, wdata: d};
    @(posedge CLK);
    #1;
    HOST_REQ.wr = 1'b0;
    HOST_REQ.wdata = ~d;
  endtask
  // Present the index, take the registered answer next edge.
  task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge CLK);
    #1;
    HOST_REQ.addr = a;
    @(posedge CLK);
    #1;
    d = HOST_RDATA;
  endtask
  // Poll of the status and fault words.
  task automatic poll(output logic [15:0] sts, output logic [15:0] flt);
    read_reg(REG_STATUS, sts);
    read_reg(REG_FAULT, flt);
  endtask
endmodule // dsh_host_model
`default_nettype wire

// ---- bench/dsh_supervisor_properties.sv ----
// Port checks on the drive supervisor.
// Assumes a bind to every supervisor instance.
`timescale 1ns/10ps
`default_nettype none
module dsh_supervisor_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic START_SW,
  input wire logic REVERSE_SW,
  input wire logic OVERCURRENT_IN,
  input wire logic LINE_120V,
  input wire dsh_pkg::dsh_host_req_t HOST_REQ,
  input wire logic [15:0] HOST_RDATA,
  input wire dsh_pkg::dsh_lamps_t LAMPS,
  input wire logic PWM_ENABLE,
  input wire logic DIRECTION_REV,
  input wire logic HOST_MODE
);
  import dsh_pkg::*;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Reset leaves local mode, motor and lamps off.
  property p_reset_out;
    $fell(RST) |-> !HOST_MODE && !PWM_ENABLE && LAMPS == 3'b000;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("bad reset outputs");
  // Run lamp implies status lamp, never fault lamp.
  property p_run_lamp;
    LAMPS.run |-> LAMPS.status && !LAMPS.fault;
  endproperty
  a_run_lamp: assert property (p_run_lamp) else $error("run lamp mix");
  // Status and fault lamps never lit together.
  property p_status_lamp;
    LAMPS.status |-> !LAMPS.fault;
  endproperty
  a_status_lamp: assert property (p_status_lamp) else $error("both lamps lit");
  // Overcurrent edge drops PWM within eight cycles.
  property p_oc_stop;
    $rose(OVERCURRENT_IN) |-> ##[1:8] !PWM_ENABLE;
  endproperty
  a_oc_stop: assert property (p_oc_stop) else $error("PWM on overcurrent");
  // Mode changes only with the switch at start.
  property p_mode_change;
    $changed(HOST_MODE) |-> START_SW;
  endproperty
  a_mode_change: assert property (p_mode_change) else $error("mode changed at stop");
  // Switch held at stop darkens the run lamp.
  property p_stop_sw;
    (!START_SW) [*6] |=> !LAMPS.run;
  endproperty
  a_stop_sw: assert property (p_stop_sw) else $error("run lamp lit at stop");
  // Local direction follows the switch.
  property p_local_dir;
    (!HOST_MODE && $stable(REVERSE_SW)) [*5] |-> DIRECTION_REV == REVERSE_SW;
  endproperty
  a_local_dir: assert property (p_local_dir) else $error("direction wrong");
  // Status read shows the line voltage.
  property p_line120;
    ($stable(LINE_120V) && HOST_REQ.addr == REG_STATUS) [*3] |=>
      HOST_RDATA[STS_LINE120] == LINE_120V;
  endproperty
  a_line120: assert property (p_line120) else $error("line bit wrong");
  // Reserved bits and unmapped indices read zero.
  property p_reserved;
    (HOST_RDATA & ($past(HOST_REQ.addr) == REG_CONTROL ? 16'hff7c :
      $past(HOST_REQ.addr) == REG_STATUS ? 16'hfff4 :
      $past(HOST_REQ.addr) == REG_FAULT ? 16'hfff8 :
      $past(HOST_REQ.addr) >= 4'hc ? 16'hffff : 16'h0000)) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");
  // Main scenarios.
  c_host_mode: cover property ($rose(HOST_MODE));
  c_run: cover property ($rose(LAMPS.run));
  c_blink: cover property ($fell(LAMPS.fault));
endmodule // dsh_supervisor_checker
bind dsh_supervisor dsh_supervisor_checker u_chk (.CLK(CLK), .RST(RST), .START_SW(START_SW),
  .REVERSE_SW(REVERSE_SW), .OVERCURRENT_IN(OVERCURRENT_IN), .LINE_120V(LINE_120V),
  .HOST_REQ(HOST_REQ), .HOST_RDATA(HOST_RDATA), .LAMPS(LAMPS), .PWM_ENABLE(PWM_ENABLE),
  .DIRECTION_REV(DIRECTION_REV), .HOST_MODE(HOST_MODE));
`default_nettype wire

// ---- bench/test_drive_supervisor_host_control.sv ----
// Self-checking bench for the drive supervisor.
// Assumes the checker binds itself; timing shortened.
`timescale 1ns/10ps
`default_nettype none
module test_drive_supervisor_host_control;
  import dsh_pkg::*;
  typedef struct packed {logic [3:0] addr; logic [15:0] wdata; logic [15:0] exp;} dsh_row_t;
  logic CLK, RST, START_SW, REVERSE_SW, TACHO_IN, OVERCURRENT_IN, OVERHEAT_IN;
  logic LINE_120V, INIT_ERROR, HOST_CMD_VALID, PWM_ENABLE, DIRECTION_REV, HOST_MODE, prev;
  logic [15:0] POT_SPEED, HOST_RDATA, INV_FREQ, AMPLITUDE, rd, rd2;
  logic [9:0] BUS_VOLTAGE;
  logic [7:0] HOST_CMD_CODE;
  dsh_host_req_t HOST_REQ;
  dsh_lamps_t LAMPS;
  int failures, samples_checked, toggles;
  dsh_row_t rows [7];
  dsh_supervisor #(.PI_TICK_CYCLES(16), .BLINK_HALF_CYCLES(8)) dut (.CLK(CLK), .RST(RST),
    .START_SW(START_SW), .REVERSE_SW(REVERSE_SW), .TACHO_IN(TACHO_IN),
    .OVERCURRENT_IN(OVERCURRENT_IN), .OVERHEAT_IN(OVERHEAT_IN), .POT_SPEED(POT_SPEED),
    .BUS_VOLTAGE(BUS_VOLTAGE), .LINE_120V(LINE_120V), .INIT_ERROR(INIT_ERROR),
    .HOST_CMD_VALID(HOST_CMD_VALID), .HOST_CMD_CODE(HOST_CMD_CODE), .HOST_REQ(HOST_REQ),
    .HOST_RDATA(HOST_RDATA), .LAMPS(LAMPS), .PWM_ENABLE(PWM_ENABLE),
    .DIRECTION_REV(DIRECTION_REV), .HOST_MODE(HOST_MODE), .INV_FREQ(INV_FREQ),
    .AMPLITUDE(AMPLITUDE));
  dsh_host_model u_host (.CLK(CLK), .HOST_RDATA(HOST_RDATA), .HOST_CMD_VALID(HOST_CMD_VALID),
    .HOST_CMD_CODE(HOST_CMD_CODE), .HOST_REQ(HOST_REQ));
  // 20 MHz clock.
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // Slow tachometer pulses, just after rising edges.
  initial begin
    TACHO_IN = 1'b0;
    #26;
    forever #1000 TACHO_IN = ~TACHO_IN;
  end
  // Waits n edges, then 1 ns.
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // One compare per kind of result.
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic chk_lamps(input dsh_lamps_t got, input dsh_lamps_t exp);
    chk_word({13'h0000, got}, {13'h0000, exp});
  endtask
  // Bounded wait for the mode output.
  task automatic wait_mode(input logic v);
    for (int i = 0; i < 20 && HOST_MODE !== v; i++) cyc(1);
    if (HOST_MODE !== v) begin
      failures++;
      $display("BAD t=%0t mode stuck", $time);
      end_sim();
    end
  endtask
  // Counts fault lamp changes over n cycles.
  task automatic count_toggles(input int n);
    toggles = 0;
    repeat (n) begin
      prev = LAMPS.fault;
      cyc(1);
      if (LAMPS.fault !== prev) toggles++;
    end
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset, refusals, mode change, rows, faults.
  initial begin
    RST = 1'b1;
    {START_SW, REVERSE_SW, OVERCURRENT_IN, OVERHEAT_IN, LINE_120V, INIT_ERROR} = '0;
    POT_SPEED = 16'h0000;
    BUS_VOLTAGE = 10'h100;
    failures = 0;
    samples_checked = 0;
    rows = '{'{REG_CONTROL, 16'hfffe, 16'h0082}, '{REG_SETPOINT, 16'h1234, 16'h1234},
      '{REG_RAMP_STEP, 16'h0055, 16'h0055}, '{REG_KP, 16'h00a0, 16'h00a0},
      '{REG_KI, 16'h0011, 16'h0011}, '{REG_FAULT, 16'h00ff, 16'h0000},
      '{4'hc, 16'hffff, 16'h0000}};
    cyc(12);
    RST = 1'b0;
    cyc(1);
    chk_bit(HOST_MODE, 1'b0);
    chk_lamps(LAMPS, 3'b000);
    u_host.write_reg(REG_CONTROL, 16'h0003);
    u_host.read_reg(REG_CONTROL, rd);
    chk_word(rd, 16'h0080);
    note("reset");
    START_SW = 1'b1;
    cyc(10);
    chk_lamps(LAMPS, 3'b110);
    u_host.read_reg(REG_STATUS, rd);
    chk_word(rd, 16'h0001);
    u_host.send_cmd(CMD_HOST_MODE);
    START_SW = 1'b0;
    cyc(10);
    START_SW = 1'b1;
    cyc(10);
    chk_bit(HOST_MODE, 1'b0);
    START_SW = 1'b0;
    cyc(20);
    u_host.send_cmd(CMD_HOST_MODE);
    cyc(10);
    chk_bit(HOST_MODE, 1'b0);
    START_SW = 1'b1;
    wait_mode(1'b1);
    chk_bit(HOST_MODE, 1'b1);
    note("mode");
    foreach (rows[i]) begin
      u_host.write_reg(rows[i].addr, rows[i].wdata);
      u_host.read_reg(rows[i].addr, rd);
      chk_word(rd, rows[i].exp);
    end
    chk_bit(DIRECTION_REV, 1'b1);
    u_host.write_reg(REG_CONTROL, 16'h0001);
    cyc(10);
    chk_lamps(LAMPS, 3'b110);
    START_SW = 1'b0;
    cyc(10);
    chk_bit(LAMPS.run, 1'b0);
    note("rows");
    OVERCURRENT_IN = 1'b1;
    cyc(6);
    OVERCURRENT_IN = 1'b0;
    OVERHEAT_IN = 1'b1;
    cyc(6);
    OVERHEAT_IN = 1'b0;
    cyc(6);
    chk_bit(PWM_ENABLE, 1'b0);
    u_host.poll(rd2, rd);
    chk_word(rd, 16'h0003);
    count_toggles(40);
    chk_bit(toggles >= 3 && toggles <= 6, 1'b1);
    chk_bit(LAMPS.status, 1'b0);
    u_host.write_reg(REG_CONTROL, 16'h0000);
    u_host.read_reg(REG_FAULT, rd);
    chk_word(rd, 16'h0000);
    cyc(10);
    chk_bit(LAMPS.fault, 1'b0);
    note("fault");
    cyc(2000);
    u_host.send_cmd(CMD_LOCAL_MODE);
    cyc(5);
    START_SW = 1'b1;
    wait_mode(1'b0);
    chk_bit(HOST_MODE, 1'b0);
    REVERSE_SW = 1'b1;
    LINE_120V = 1'b1;
    cyc(8);
    chk_bit(DIRECTION_REV, 1'b1);
    u_host.read_reg(REG_STATUS, rd);
    chk_word(rd, 16'h0009);
    note("local");
    INIT_ERROR = 1'b1;
    cyc(1);
    INIT_ERROR = 1'b0;
    cyc(10);
    count_toggles(40);
    chk_bit(toggles == 0, 1'b1);
    chk_lamps(LAMPS, 3'b001);
    RST = 1'b1;
    cyc(2);
    RST = 1'b0;
    cyc(1);
    chk_bit(HOST_MODE, 1'b0);
    chk_lamps(LAMPS, 3'b000);
    chk_word(INV_FREQ, 16'h0000);
    chk_word(AMPLITUDE, 16'h0800);
    note("init error");
    end_sim();
  end
endmodule // test_drive_supervisor_host_control
`default_nettype wire

// ---- logic/dsh_pkg.sv ----
// Package for the drive supervisor: register indices, field positions,
// reset values, timing constants, state enumerations and carrier structs.
// Assumes a single 20 MHz system clock shared by every user of the package.
package dsh_pkg;

  // Clock rate and timing figures.
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned PI_PERIOD_US = 1000;
  localparam int unsigned PI_CYCLES = CLK_HZ / 1000000 * PI_PERIOD_US;
  localparam int unsigned BLINK_HALF_MS = 1000;
  localparam int unsigned BLINK_CYCLES = CLK_HZ / 1000 * BLINK_HALF_MS;

  // Host command codes.
  localparam logic [7:0] CMD_LOCAL_MODE = 8'h00;
  localparam logic [7:0] CMD_HOST_MODE = 8'h01;

  // Register indices on the host access port.
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_FAULT = 4'h2;
  localparam logic [3:0] REG_SETPOINT = 4'h3;
  localparam logic [3:0] REG_RAMP_SPEED = 4'h4;
  localparam logic [3:0] REG_TACHO_SPEED = 4'h5;
  localparam logic [3:0] REG_BUS_VOLT = 4'h6;
  localparam logic [3:0] REG_INV_FREQ = 4'h7;
  localparam logic [3:0] REG_AMPLITUDE = 4'h8;
  localparam logic [3:0] REG_RAMP_STEP = 4'h9;
  localparam logic [3:0] REG_KP = 4'ha;
  localparam logic [3:0] REG_KI = 4'hb;

  // Field positions.
  localparam int CTL_START = 0;
  localparam int CTL_REVERSE = 1;
  localparam int CTL_ERR_KEEP = 7;
  localparam int STS_SWITCH = 0;
  localparam int STS_RUNNING = 1;
  localparam int STS_LINE120 = 3;
  localparam int FLT_OVERCURRENT = 0;
  localparam int FLT_OVERHEAT = 1;
  localparam int FLT_OVERVOLT = 2;
  localparam logic [7:0] CTL_WMASK = 8'h83;

  // Reset values.
  localparam logic [7:0] CTL_RESET = 8'h80;
  localparam logic [15:0] RAMP_STEP_RESET = 16'h0040;
  localparam logic [15:0] KP_RESET = 16'h0080;
  localparam logic [15:0] KI_RESET = 16'h0010;

  // Fixed-point speed format: 8 integer bits, 8 fraction bits.
  localparam int FRAC_BITS = 8;
  localparam logic [15:0] SPEED_MAX = 16'h5000;

  // Pin index of each synchronised input.
  localparam int PIN_START = 0;
  localparam int PIN_REVERSE = 1;
  localparam int PIN_TACHO = 2;
  localparam int PIN_OVERCURRENT = 3;
  localparam int PIN_OVERHEAT = 4;
  localparam int PIN_COUNT = 5;

  typedef enum logic [1:0] {MODE_LOCAL, MODE_HOST} dsh_mode_t;
  typedef enum logic [2:0] {ST_STANDBY, ST_RUN, ST_STOP, ST_FAULT, ST_INIT_ERR} dsh_state_t;

  // One host access: write strobe, register index and write data.
  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [15:0] wdata;
  } dsh_host_req_t;

  // The three indicator lamps, all active high.
  typedef struct packed {
    logic run;
    logic status;
    logic fault;
  } dsh_lamps_t;

endpackage

// ---- logic/dsh_supervisor.sv ----
// Drive supervisor: host mode commands, control/status/fault words, lamp
// driver, speed ramp with deceleration hold, tachometer speed, PI loop and
// volt-per-hertz amplitude. Assumes the serial framing is decoded outside
// into single-cycle command and access strobes on CLK, and that the bus
// voltage word and line detection come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// [RQ1] Command 00 selects local switch control
// [RQ2] Command 01 selects host serial control
// [RQ3] Host polls status and faults each second
// [RQ4] Control bits: start/stop, direction; 2-6 reserved
// [RQ5] Control bit 7 written zero clears errors
// [RQ6] Status bits: switch position, motor running
// [RQ7] Status bit 3: 120 V line detected
// [RQ8] Fault bits: overcurrent, overheat, overvoltage
// [RQ9] Mode command accepted only while fully stopped
// [RQ10] New mode applies at next switch start
// [RQ11] Local mode after reset
// [RQ12] Stop switch always stops motor
// [RQ13] Host mode reads/writes other internal variables
// [RQ14] Lamps active high; run lamp in run
// [RQ15] Status lamp lit in run and stop
// [RQ16] Fault lamp: steady init error, blinks faults
// [RQ17] Overcurrent/overvoltage disables PWM, shows fault
// [RQ18] Speeds are 8.8 unsigned fixed point
// [RQ19] Deceleration holds speed during bus overvoltage
// [RQ20] Speed from tachometer rising-edge period, averaged
// [RQ21] PI of ramped command minus measured speed
// [RQ22] Amplitude follows frequency with base and boost
// [RQ23] Reserved bits read zero, writes ignored
// [RQ24] Speed command follows a rate-limited ramp
module dsh_supervisor #(
  parameter int unsigned PI_TICK_CYCLES = dsh_pkg::PI_CYCLES,
  parameter int unsigned BLINK_HALF_CYCLES = dsh_pkg::BLINK_CYCLES,
  parameter logic [9:0] OV_LIMIT = 10'h3c0,
  parameter logic [9:0] DECEL_HOLD_LIMIT = 10'h370,
  parameter logic [31:0] TACHO_K = 32'h0100_0000,
  parameter logic [15:0] BASE_FREQ = 16'h3200,
  parameter logic [15:0] BOOST_FREQ = 16'h0500,
  parameter logic [15:0] BOOST_AMP = 16'h0800,
  parameter logic [15:0] FULL_AMP = 16'hffff
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic START_SW,
  input wire logic REVERSE_SW,
  input wire logic TACHO_IN,
  input wire logic OVERCURRENT_IN,
  input wire logic OVERHEAT_IN,
  input wire logic [15:0] POT_SPEED,
  input wire logic [9:0] BUS_VOLTAGE,
  input wire logic LINE_120V,
  input wire logic INIT_ERROR,
  input wire logic HOST_CMD_VALID,
  input wire logic [7:0] HOST_CMD_CODE,
  input wire dsh_pkg::dsh_host_req_t HOST_REQ,
  output logic [15:0] HOST_RDATA,
  output dsh_pkg::dsh_lamps_t LAMPS,
  output logic PWM_ENABLE,
  output logic DIRECTION_REV,
  output logic HOST_MODE,
  output logic [15:0] INV_FREQ,
  output logic [15:0] AMPLITUDE
);
  import dsh_pkg::*;

  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_s1_reg;
  logic [PIN_COUNT-1:0] pin_s2_reg;
  logic [PIN_COUNT-1:0] pin_s3_reg;
  logic [PIN_COUNT-1:0] pin_reg;
  logic tacho_prev_reg;
  logic oc_prev_reg;
  logic start_prev_reg;
  logic start_rise;
  dsh_mode_t operating_selection_reg;
  dsh_mode_t pending_mode_reg;
  dsh_state_t state_reg;
  dsh_state_t state_next;
  logic [7:0] ctl_reg;
  logic [7:0] fault_reg;
  logic [7:0] status_word;
  logic [15:0] setpoint_reg;
  logic [15:0] ramp_step_reg;
  logic [15:0] kp_reg;
  logic [15:0] ki_reg;
  logic [15:0] ramp_reg;
  logic [15:0] tacho_speed_reg;
  logic [15:0] inv_freq_reg;
  logic [15:0] amp_reg;
  logic [15:0] target_speed;
  logic [31:0] pi_cnt_reg;
  logic pi_tick;
  logic [31:0] blink_cnt_reg;
  logic blink_reg;
  logic [19:0] period_cnt_reg;
  logic [19:0] period_hist_reg [4];
  logic [21:0] period_sum;
  logic init_err_reg;
  logic run_req;
  logic general_fault_flag;
  logic decelerating;
  logic ov_event;
  logic clear_errors;
  logic host_wr;
  logic signed [17:0] speed_err;
  logic signed [31:0] integ_reg;
  logic signed [33:0] pi_sum;

  // Three-stage synchronisers; a change counts once stages two and three agree.
  assign pin_raw = {OVERHEAT_IN, OVERCURRENT_IN, TACHO_IN, REVERSE_SW, START_SW};
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge CLK) begin
        if (RST) begin
          pin_s1_reg[gi] <= 1'b0;
          pin_s2_reg[gi] <= 1'b0;
          pin_s3_reg[gi] <= 1'b0;
          pin_reg[gi] <= 1'b0;
        end else begin
          pin_s1_reg[gi] <= pin_raw[gi];
          pin_s2_reg[gi] <= pin_s1_reg[gi];
          pin_s3_reg[gi] <= pin_s2_reg[gi];
          if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
            pin_reg[gi] <= pin_s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  // Edge history for the start switch, tachometer and overcurrent inputs.
  always_ff @(posedge CLK) begin
    if (RST) begin
      start_prev_reg <= 1'b0;
      tacho_prev_reg <= 1'b0;
      oc_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= pin_reg[PIN_START];
      tacho_prev_reg <= pin_reg[PIN_TACHO];
      oc_prev_reg <= pin_reg[PIN_OVERCURRENT];
    end
  end
  assign start_rise = pin_reg[PIN_START] & ~start_prev_reg;

  // Host writes to the tunable variables are honoured only in host mode.
  assign host_wr = HOST_REQ.wr && (operating_selection_reg == MODE_HOST); // RQ13

  // Mode request is latched only when stopped, then applied at switch start.
  always_ff @(posedge CLK) begin
    if (RST) begin
      operating_selection_reg <= MODE_LOCAL; // RQ11
      pending_mode_reg <= MODE_LOCAL;
    end else begin
      if (HOST_CMD_VALID && !pin_reg[PIN_START] && state_reg != ST_RUN
          && ramp_reg == '0) begin // RQ9
        if (HOST_CMD_CODE == CMD_LOCAL_MODE) begin
          pending_mode_reg <= MODE_LOCAL; // RQ1
        end else if (HOST_CMD_CODE == CMD_HOST_MODE) begin
          pending_mode_reg <= MODE_HOST; // RQ2
        end
      end
      if (start_rise) begin
        operating_selection_reg <= pending_mode_reg; // RQ10
      end
    end
  end

  // Control word and host-writable variables; reserved bits never store.
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctl_reg <= CTL_RESET;
      setpoint_reg <= '0;
      ramp_step_reg <= RAMP_STEP_RESET;
      kp_reg <= KP_RESET;
      ki_reg <= KI_RESET;
    end else if (host_wr) begin
      case (HOST_REQ.addr)
        REG_CONTROL: ctl_reg <= HOST_REQ.wdata[7:0] & CTL_WMASK; // RQ4 RQ23
        REG_SETPOINT: setpoint_reg <= HOST_REQ.wdata;
        REG_RAMP_STEP: ramp_step_reg <= HOST_REQ.wdata;
        REG_KP: kp_reg <= HOST_REQ.wdata;
        REG_KI: ki_reg <= HOST_REQ.wdata;
        default: ctl_reg <= ctl_reg;
      endcase
    end
  end
  assign clear_errors = host_wr && HOST_REQ.addr == REG_CONTROL
                        && !HOST_REQ.wdata[CTL_ERR_KEEP]; // RQ5

  // Fault record: a new event in the clearing cycle wins over the clear.
  assign decelerating = (state_reg == ST_STOP) || (ramp_reg > target_speed);
  assign ov_event = decelerating && (BUS_VOLTAGE > OV_LIMIT);
  always_ff @(posedge CLK) begin
    if (RST) begin
      fault_reg <= '0;
    end else begin
      if (clear_errors) begin
        fault_reg <= '0; // RQ5
      end
      if (pin_reg[PIN_OVERCURRENT] && !oc_prev_reg) begin
        fault_reg[FLT_OVERCURRENT] <= 1'b1; // RQ8
      end
      if (pin_reg[PIN_OVERHEAT]) begin
        fault_reg[FLT_OVERHEAT] <= 1'b1; // RQ8
      end
      if (ov_event) begin
        fault_reg[FLT_OVERVOLT] <= 1'b1; // RQ8
      end
    end
  end
  assign general_fault_flag = fault_reg[FLT_OVERCURRENT] | fault_reg[FLT_OVERVOLT];

  // Initialization error is caught after reset and held until the next reset.
  always_ff @(posedge CLK) begin
    if (RST) begin
      init_err_reg <= 1'b0;
    end else if (INIT_ERROR) begin
      init_err_reg <= 1'b1;
    end
  end

  // Run request; the switch at stop always wins in host mode.
  always_comb begin
    if (operating_selection_reg == MODE_HOST) begin
      run_req = ctl_reg[CTL_START] & pin_reg[PIN_START]; // RQ12
      DIRECTION_REV = ctl_reg[CTL_REVERSE]; // RQ4
      target_speed = setpoint_reg;
    end else begin
      run_req = pin_reg[PIN_START];
      DIRECTION_REV = pin_reg[PIN_REVERSE];
      target_speed = POT_SPEED;
    end
    if (!run_req || target_speed > SPEED_MAX) begin
      target_speed = run_req ? SPEED_MAX : '0;
    end
  end

  // Drive state machine.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_STANDBY: if (run_req) state_next = ST_RUN;
      ST_RUN: if (!run_req) state_next = ST_STOP;
      ST_STOP: begin
        if (run_req) begin
          state_next = ST_RUN;
        end else if (ramp_reg == '0) begin
          state_next = ST_STANDBY;
        end
      end
      ST_FAULT: if (!general_fault_flag && !run_req) state_next = ST_STANDBY;
      ST_INIT_ERR: state_next = ST_INIT_ERR;
      default: state_next = ST_STANDBY;
    endcase
    if (general_fault_flag && state_reg != ST_INIT_ERR) begin
      state_next = ST_FAULT; // RQ17
    end
    if (init_err_reg) begin
      state_next = ST_INIT_ERR;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= ST_STANDBY;
    end else begin
      state_reg <= state_next;
    end
  end

  // Control loop timebase.
  always_ff @(posedge CLK) begin
    if (RST || pi_tick) begin
      pi_cnt_reg <= '0;
    end else begin
      pi_cnt_reg <= pi_cnt_reg + 32'd1;
    end
  end
  assign pi_tick = (pi_cnt_reg == PI_TICK_CYCLES - 1);

  // Rate-limited ramp; deceleration pauses while the bus voltage is high.
  always_ff @(posedge CLK) begin
    if (RST || state_reg == ST_FAULT || state_reg == ST_INIT_ERR) begin
      ramp_reg <= '0;
    end else if (pi_tick) begin
      if (ramp_reg < target_speed) begin
        ramp_reg <= (target_speed - ramp_reg > ramp_step_reg) ?
                    ramp_reg + ramp_step_reg : target_speed; // RQ24
      end else if (ramp_reg > target_speed && BUS_VOLTAGE <= DECEL_HOLD_LIMIT) begin // RQ19
        ramp_reg <= (ramp_reg - target_speed > ramp_step_reg) ?
                    ramp_reg - ramp_step_reg : target_speed; // RQ24
      end
    end
  end

  // Tachometer period between rising edges, averaged over four periods.
  assign period_sum = {2'b00, period_hist_reg[0]} + {2'b00, period_hist_reg[1]}
                    + {2'b00, period_hist_reg[2]} + {2'b00, period_hist_reg[3]}; // RQ20
  always_ff @(posedge CLK) begin
    if (RST) begin
      period_cnt_reg <= '0;
      for (int i = 0; i < 4; i++) begin
        period_hist_reg[i] <= '1;
      end
    end else if (pin_reg[PIN_TACHO] && !tacho_prev_reg) begin
      period_cnt_reg <= '0;
      period_hist_reg[0] <= period_cnt_reg; // RQ20
      for (int i = 1; i < 4; i++) begin
        period_hist_reg[i] <= period_hist_reg[i-1];
      end
    end else if (period_cnt_reg != '1) begin
      period_cnt_reg <= period_cnt_reg + 20'd1;
    end
  end

  // Measured speed in 8.8 format, refreshed each loop tick.
  always_ff @(posedge CLK) begin
    if (RST) begin
      tacho_speed_reg <= '0;
    end else if (pi_tick) begin
      tacho_speed_reg <= 16'(TACHO_K / {10'd0, period_sum[21:2] | 20'd1}); // RQ18
    end
  end

  // PI controller on the ramped command minus the measured speed.
  assign speed_err = $signed({2'b00, ramp_reg}) - $signed({2'b00, tacho_speed_reg}); // RQ21
  assign pi_sum = $signed({18'd0, ramp_reg})
                + 34'(($signed({1'b0, kp_reg}) * speed_err) >>> FRAC_BITS)
                + 34'(integ_reg);
  always_ff @(posedge CLK) begin
    if (RST || ramp_reg == '0) begin
      integ_reg <= '0;
      inv_freq_reg <= '0;
    end else if (pi_tick) begin
      integ_reg <= integ_reg + 32'(($signed({1'b0, ki_reg}) * speed_err) >>> FRAC_BITS);
      if (pi_sum < 0) begin
        inv_freq_reg <= '0; // RQ21
      end else if (pi_sum > $signed({18'd0, SPEED_MAX})) begin
        inv_freq_reg <= SPEED_MAX;
      end else begin
        inv_freq_reg <= pi_sum[15:0];
      end
    end
  end

  // Volt-per-hertz amplitude with boost floor and base-point ceiling.
  always_ff @(posedge CLK) begin
    if (RST) begin
      amp_reg <= '0;
    end else if (inv_freq_reg <= BOOST_FREQ) begin
      amp_reg <= BOOST_AMP; // RQ22
    end else if (inv_freq_reg >= BASE_FREQ) begin
      amp_reg <= FULL_AMP; // RQ22
    end else begin
      amp_reg <= BOOST_AMP + 16'((32'(inv_freq_reg - BOOST_FREQ) * 32'(FULL_AMP - BOOST_AMP))
                 / 32'(BASE_FREQ - BOOST_FREQ)); // RQ22
    end
  end

  // Fault lamp blink: one second on, one second off.
  always_ff @(posedge CLK) begin
    if (RST || state_reg != ST_FAULT) begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b1;
    end else if (blink_cnt_reg == BLINK_HALF_CYCLES - 1) begin
      blink_cnt_reg <= '0;
      blink_reg <= ~blink_reg; // RQ16
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'd1;
    end
  end

  // Lamps are registered from the drive state, all active high.
  always_ff @(posedge CLK) begin
    if (RST) begin
      LAMPS <= '0;
    end else begin
      LAMPS.run <= (state_reg == ST_RUN); // RQ14
      LAMPS.status <= (state_reg == ST_RUN) || (state_reg == ST_STOP); // RQ15
      LAMPS.fault <= (state_reg == ST_INIT_ERR)
                     || (state_reg == ST_FAULT && blink_reg); // RQ16
    end
  end

  // Status word with reserved bits held at zero.
  always_comb begin
    status_word = '0; // RQ23
    status_word[STS_SWITCH] = pin_reg[PIN_START]; // RQ6
    status_word[STS_RUNNING] = (ramp_reg != '0) && (state_reg == ST_RUN || state_reg == ST_STOP); // RQ6
    status_word[STS_LINE120] = LINE_120V; // RQ7
  end

  // Registered read data for the host; unmapped indices read zero.
  always_ff @(posedge CLK) begin
    if (RST) begin
      HOST_RDATA <= '0;
    end else begin
      case (HOST_REQ.addr)
        REG_CONTROL: HOST_RDATA <= {8'h00, ctl_reg};
        REG_STATUS: HOST_RDATA <= {8'h00, status_word};
        REG_FAULT: HOST_RDATA <= {8'h00, fault_reg};
        REG_SETPOINT: HOST_RDATA <= setpoint_reg;
        REG_RAMP_SPEED: HOST_RDATA <= ramp_reg;
        REG_TACHO_SPEED: HOST_RDATA <= tacho_speed_reg;
        REG_BUS_VOLT: HOST_RDATA <= {6'h00, BUS_VOLTAGE};
        REG_INV_FREQ: HOST_RDATA <= inv_freq_reg;
        REG_AMPLITUDE: HOST_RDATA <= amp_reg;
        REG_RAMP_STEP: HOST_RDATA <= ramp_step_reg;
        REG_KP: HOST_RDATA <= kp_reg;
        REG_KI: HOST_RDATA <= ki_reg;
        default: HOST_RDATA <= '0;
      endcase
    end
  end

  // Motor outputs; PWM drops at once on an overcurrent or overvoltage fault, or on entering the init error state.
  assign PWM_ENABLE = (state_reg == ST_RUN || state_reg == ST_STOP) && !general_fault_flag; // RQ17
  assign HOST_MODE = (operating_selection_reg == MODE_HOST);
  assign INV_FREQ = inv_freq_reg;
  assign AMPLITUDE = amp_reg;

endmodule // dsh_supervisor

`default_nettype wire
